// ==== rtl/tcp_timer16.sv ====
/*
  16-bit timer core: input capture with shared byte latch and dual pwm
  (phase correct or fast, 8/9/10 bit), registers over axi4-lite.
  assumes the counter ticks every i_clk and the capture pin is asynchronous.
*/
// Local design decision: the AXI4-Lite interface to the registers.
// What this block does
// - capture edge copies counter into capture register
// - capture also sets capture flag
// - capture register 16 bits, read only, resets zero
// - low read latches high byte for later
// - phase mode counts up to ceiling, down
// - resolution picks ceiling 255, 511 or 1023
// - period 510/1022/2046 or 256/512/1024 clocks
// - match on low resolution bits drives pin
// - bits above resolution forced to zero
// - phase mode: 10 clears up, sets down
// - fast mode: 10 clears on match, sets wrap
// - compare buffered, latched at the ceiling
// - compare read returns the holding buffer
// - phase mode zero and ceiling give constant
// - fast mode constant only at ceiling
// - edge select zero falling, one rising
// - noise cancel needs four equal samples
// - overflow flag: phase from zero, fast wrap
`timescale 1ns/10ps
`include "tcp_defs.svh"
module tcp_timer16
(
  // clock and reset
  input  wire logic                 i_clk,
  input  wire logic                 i_srst,
  // axi4-lite write address and data
  input  wire logic [7:0]           i_s_axi_awaddr,
  input  wire logic                 i_s_axi_awvalid,
  output wire logic                 o_s_axi_awready,
  input  wire logic [31:0]          i_s_axi_wdata,
  input  wire logic [3:0]           i_s_axi_wstrb,
  input  wire logic                 i_s_axi_wvalid,
  output wire logic                 o_s_axi_wready,
  // axi4-lite write response
  output logic      [1:0]           o_s_axi_bresp,
  output logic                      o_s_axi_bvalid,
  input  wire logic                 i_s_axi_bready,
  // axi4-lite read
  input  wire logic [7:0]           i_s_axi_araddr,
  input  wire logic                 i_s_axi_arvalid,
  output wire logic                 o_s_axi_arready,
  output logic      [31:0]          o_s_axi_rdata,
  output logic      [1:0]           o_s_axi_rresp,
  output logic                      o_s_axi_rvalid,
  input  wire logic                 i_s_axi_rready,
  // capture pin and pwm pins
  input  wire logic                 i_capture_pin,
  output logic                      o_pwm_out_a,
  output logic                      o_pwm_out_a_oe,
  output logic                      o_pwm_out_b,
  output logic                      o_pwm_out_b_oe
);
  import tcp_pkg::*;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst);

  tcp_cap_if cap ();

  // registers
  tcp_word_t counter_value_r;   // running count
  tcp_dir_e  dir_r;             // phase-correct direction
  tcp_word_t capture_reg_r;     // captured count
  tcp_word_t hold_a_r;          // written compare a
  tcp_word_t hold_b_r;          // written compare b
  tcp_word_t act_a_r;           // compare a in use
  tcp_word_t act_b_r;           // compare b in use
  logic [7:0] temp_r;           // shared byte latch
  logic [7:0] ctl_a_r;          // timer_control_a
  logic [7:0] capctl_r;         // capture control
  logic       capture_flag_r;
  logic       overflow_flag_r;

  // decoded control
  tcp_res_e  res;
  tcp_com_e  mode_a, mode_b;
  logic      pwm_on, fast, ovf_evt, at_top, at_zero, up_now, match_a, match_b;
  tcp_word_t top, cnt_m;

  // bus handshakes
  logic       wr_go, rd_go;
  logic [5:0] wr_idx, rd_idx;
  logic [7:0] wbyte;

  // ceiling for a resolution; also the mask of live bits
  function automatic tcp_word_t top_of(input tcp_res_e r);
    case (r)
      TCP_RES_8:  top_of = `TCP_TOP8;
      TCP_RES_9:  top_of = `TCP_TOP9;
      TCP_RES_10: top_of = `TCP_TOP10;
      default:    top_of = `TCP_MAX16;
    endcase
  endfunction : top_of

  // mapped register index check, used by both bus directions
  function automatic logic mapped(input logic [5:0] idx);
    mapped = (idx >= `TCP_IDX_CAP_LO && idx <= `TCP_IDX_CTL_A) || idx == `TCP_IDX_STATUS;
  endfunction : mapped

  // next pin level of one channel
  function automatic logic pin_next(input tcp_com_e m, input logic fst, input logic mt,
                                    input logic wrap, input logic up, input logic cur);
    pin_next = cur;
    if (fst)
    begin
      if (wrap)
        pin_next = (m == TCP_COM_CLR);
      else if (mt)
        pin_next = (m == TCP_COM_SET);
    end
    else if (mt)
      pin_next = (m == TCP_COM_CLR) ? ~up : up;
  endfunction : pin_next

  assign res     = tcp_res_e'(ctl_a_r[`TCP_CTL_RES]);
  assign mode_a  = tcp_com_e'(ctl_a_r[`TCP_CTL_MODE_A]);
  assign mode_b  = tcp_com_e'(ctl_a_r[`TCP_CTL_MODE_B]);
  assign pwm_on  = (res != TCP_RES_NORMAL);
  assign fast    = ctl_a_r[`TCP_BIT_CTC];
  assign top     = top_of(res);
  assign cnt_m   = counter_value_r & top;
  assign at_top  = (cnt_m == top);
  assign at_zero = (cnt_m == `TCP_RST_WORD);
  // a match at zero counts as up, at the ceiling as down
  assign up_now  = at_zero ? 1'b1 : (at_top ? 1'b0 : (dir_r == TCP_DIR_UP));
  assign match_a = pwm_on && (cnt_m == (act_a_r & top));
  assign match_b = pwm_on && (cnt_m == (act_b_r & top));
  // overflow: normal wrap, fast wrap at ceiling, phase leaving zero
  assign ovf_evt = !pwm_on ? (counter_value_r == `TCP_MAX16) : (fast ? at_top : at_zero);

  assign cap.noise_cancel = capctl_r[`TCP_BIT_NCANCEL];
  assign cap.edge_sel     = capctl_r[`TCP_BIT_EDGE];

  // capture pin front end
  tcp_cap_filter u_filter
  (
    .i_clk         (i_clk),
    .i_srst        (i_srst),
    .i_capture_pin (i_capture_pin),
    .cap           (cap)
  );

  // write takes address and data together; one response at a time
  assign wr_go           = i_s_axi_awvalid && i_s_axi_wvalid && !o_s_axi_bvalid;
  assign o_s_axi_awready = wr_go;
  assign o_s_axi_wready  = wr_go;
  assign wr_idx          = i_s_axi_awaddr[7:2];
  assign wbyte           = i_s_axi_wdata[7:0];
  assign rd_go           = i_s_axi_arvalid && !o_s_axi_rvalid;
  assign o_s_axi_arready = rd_go;
  assign rd_idx          = i_s_axi_araddr[7:2];

  // counter and direction
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      counter_value_r <= `TCP_RST_WORD;
      dir_r           <= TCP_DIR_UP;
    end
    else if (!pwm_on)
    begin
      counter_value_r <= counter_value_r + `TCP_ONE16;
      dir_r           <= TCP_DIR_UP;
    end
    else if (fast)
      counter_value_r <= at_top ? `TCP_RST_WORD : cnt_m + `TCP_ONE16;
    else
    begin
      case (dir_r)
        TCP_DIR_UP:
        begin
          if (at_top)
          begin
            counter_value_r <= cnt_m - `TCP_ONE16;
            dir_r           <= TCP_DIR_DOWN;
          end
          else
            counter_value_r <= cnt_m + `TCP_ONE16;
        end
        TCP_DIR_DOWN:
        begin
          if (at_zero)
          begin
            counter_value_r <= `TCP_ONE16;
            dir_r           <= TCP_DIR_UP;
          end
          else
            counter_value_r <= cnt_m - `TCP_ONE16;
        end
        default:
          dir_r <= TCP_DIR_UP;
      endcase
    end
  end

  // capture register; no bus path writes it
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
      capture_reg_r <= `TCP_RST_WORD;
    else if (cap.capture_evt)
      capture_reg_r <= counter_value_r;
  end

  // status flags; a new event wins over a clear in the same cycle
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      capture_flag_r  <= 1'b0;
      overflow_flag_r <= 1'b0;
    end
    else
    begin
      if (cap.capture_evt)
        capture_flag_r <= 1'b1;
      else if (wr_go && wr_idx == `TCP_IDX_STATUS && i_s_axi_wstrb[0] && wbyte[`TCP_BIT_CAPF])
        capture_flag_r <= 1'b0;
      if (ovf_evt)
        overflow_flag_r <= 1'b1;
      else if (wr_go && wr_idx == `TCP_IDX_STATUS && i_s_axi_wstrb[0] && wbyte[`TCP_BIT_OVF])
        overflow_flag_r <= 1'b0;
    end
  end

  // control registers and compare holding buffers
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      ctl_a_r  <= `TCP_RST_BYTE;
      capctl_r <= `TCP_RST_BYTE;
      hold_a_r <= `TCP_RST_WORD;
      hold_b_r <= `TCP_RST_WORD;
    end
    else if (wr_go && i_s_axi_wstrb[0])
    begin
      case (wr_idx)
        `TCP_IDX_CTL_A:   ctl_a_r  <= wbyte;
        `TCP_IDX_CAPCTL:  capctl_r <= wbyte;
        `TCP_IDX_CMPA_LO: hold_a_r <= {temp_r, wbyte};
        `TCP_IDX_CMPB_LO: hold_b_r <= {temp_r, wbyte};
        default:          ;
      endcase
    end
  end

  // shared byte latch: high writes park here, low reads park the high byte
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
      temp_r <= `TCP_RST_BYTE;
    else if (rd_go && rd_idx == `TCP_IDX_CAP_LO)
      temp_r <= capture_reg_r[15:8];
    else if (rd_go && rd_idx == `TCP_IDX_CNT_LO)
      temp_r <= counter_value_r[15:8];
    else if (wr_go && i_s_axi_wstrb[0] &&
             (wr_idx == `TCP_IDX_CMPA_HI || wr_idx == `TCP_IDX_CMPB_HI))
      temp_r <= wbyte;
  end

  // active compares load at the ceiling, or every cycle in normal counting, so no pulse is cut short
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      act_a_r <= `TCP_RST_WORD;
      act_b_r <= `TCP_RST_WORD;
    end
    else if (!pwm_on || at_top)
    begin
      act_a_r <= hold_a_r & top;
      act_b_r <= hold_b_r & top;
    end
  end

  // pin drivers; normal counting leaves the pins disconnected
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      o_pwm_out_a    <= 1'b0;
      o_pwm_out_b    <= 1'b0;
      o_pwm_out_a_oe <= 1'b0;
      o_pwm_out_b_oe <= 1'b0;
    end
    else
    begin
      o_pwm_out_a    <= pin_next(mode_a, fast, match_a, at_top && pwm_on, up_now, o_pwm_out_a);
      o_pwm_out_b    <= pin_next(mode_b, fast, match_b, at_top && pwm_on, up_now, o_pwm_out_b);
      o_pwm_out_a_oe <= pwm_on && mode_a[1];
      o_pwm_out_b_oe <= pwm_on && mode_b[1];
    end
  end

  // write response
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      o_s_axi_bvalid <= 1'b0;
      o_s_axi_bresp  <= `TCP_RESP_OKAY;
    end
    else if (wr_go)
    begin
      o_s_axi_bvalid <= 1'b1;
      o_s_axi_bresp  <= mapped(wr_idx) ? `TCP_RESP_OKAY : `TCP_RESP_SLVERR;
    end
    else if (i_s_axi_bready)
      o_s_axi_bvalid <= 1'b0;
  end

  // read data; compare reads show the holding buffer, upper bits masked
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      o_s_axi_rvalid <= 1'b0;
      o_s_axi_rdata  <= '0;
      o_s_axi_rresp  <= `TCP_RESP_OKAY;
    end
    else if (rd_go)
    begin
      o_s_axi_rvalid <= 1'b1;
      o_s_axi_rresp  <= mapped(rd_idx) ? `TCP_RESP_OKAY : `TCP_RESP_SLVERR;
      case (rd_idx)
        `TCP_IDX_CAP_LO:  o_s_axi_rdata <= {24'h000000, capture_reg_r[7:0]};
        `TCP_IDX_CAP_HI:  o_s_axi_rdata <= {24'h000000, temp_r};
        `TCP_IDX_CNT_LO:  o_s_axi_rdata <= {24'h000000, counter_value_r[7:0]};
        `TCP_IDX_CNT_HI:  o_s_axi_rdata <= {24'h000000, temp_r};
        `TCP_IDX_CMPA_LO: o_s_axi_rdata <= {24'h000000, hold_a_r[7:0]};
        `TCP_IDX_CMPA_HI: o_s_axi_rdata <= {24'h000000, hold_a_r[15:8] & top[15:8]};
        `TCP_IDX_CMPB_LO: o_s_axi_rdata <= {24'h000000, hold_b_r[7:0]};
        `TCP_IDX_CMPB_HI: o_s_axi_rdata <= {24'h000000, hold_b_r[15:8] & top[15:8]};
        `TCP_IDX_CTL_A:   o_s_axi_rdata <= {24'h000000, ctl_a_r};
        `TCP_IDX_CAPCTL:  o_s_axi_rdata <= {24'h000000, capctl_r};
        `TCP_IDX_STATUS:  o_s_axi_rdata <= {30'h0, overflow_flag_r, capture_flag_r};
        default:          o_s_axi_rdata <= '0;
      endcase
    end
    else if (i_s_axi_rready)
      o_s_axi_rvalid <= 1'b0;
  end

  // checks
  a_cap_load: assert property (cap.capture_evt |=> capture_reg_r == $past(counter_value_r))
    else $error("capture did not copy the counter");
  a_cap_flag: assert property (cap.capture_evt |=> capture_flag_r)
    else $error("capture flag not set with capture");
  a_cap_ro: assert property (!cap.capture_evt |=> $stable(capture_reg_r))
    else $error("capture register changed without capture");
  a_temp_latch: assert property ((rd_go && rd_idx == `TCP_IDX_CAP_LO)
    |=> temp_r == $past(capture_reg_r[15:8]))
    else $error("low read did not park the high byte");
  a_phase_turn: assert property ((pwm_on && !fast && at_top && dir_r == TCP_DIR_UP
    && $stable(ctl_a_r)) |=> (dir_r == TCP_DIR_DOWN) && (counter_value_r == $past(top) - 16'h0001))
    else $error("phase counter did not turn at ceiling");
  a_top_bound: assert property ((pwm_on && $stable(ctl_a_r)) |=> counter_value_r <= top)
    else $error("counter above ceiling in pwm");
  a_fast_wrap: assert property ((pwm_on && fast && at_top && $stable(ctl_a_r))
    |=> counter_value_r == 16'h0000)
    else $error("fast counter did not wrap at ceiling");
  a_cmp_latch: assert property ((pwm_on && !at_top) |=> $stable(act_a_r))
    else $error("active compare changed off the ceiling");
  a_ovf_phase: assert property ((pwm_on && !fast && at_zero) |=> overflow_flag_r)
    else $error("overflow flag missing when leaving zero");
  a_out_clear: assert property ((pwm_on && !fast && match_a && up_now && mode_a == TCP_COM_CLR)
    |=> !o_pwm_out_a)
    else $error("mode 10 up match did not clear pin a");
  a_fast_top: assert property ((pwm_on && fast && at_top && mode_b == TCP_COM_SET)
    |=> !o_pwm_out_b)
    else $error("fast mode 11 wrap did not clear pin b");

  c_capture:  cover property (cap.capture_evt ##1 capture_flag_r);
  c_phase:    cover property (pwm_on && !fast && at_top ##1 dir_r == TCP_DIR_DOWN);
  c_fast:     cover property (pwm_on && fast && match_a ##1 !o_pwm_out_a);
  c_cmp_load: cover property (pwm_on && at_top && hold_a_r != act_a_r);

endmodule : tcp_timer16

// ==== pkg/tcp_defs.svh ====
/*
  register indices, field positions, reset values and fixed counts of the
  16-bit capture / pwm timer. assumes the includer maps byte address = 4 * index.
*/
`ifndef TCP_DEFS_SVH
`define TCP_DEFS_SVH

// register indices (byte address is four times the index)
`define TCP_IDX_CAP_LO   6'h26
`define TCP_IDX_CAP_HI   6'h27
`define TCP_IDX_CMPB_LO  6'h28
`define TCP_IDX_CMPB_HI  6'h29
`define TCP_IDX_CMPA_LO  6'h2a
`define TCP_IDX_CMPA_HI  6'h2b
`define TCP_IDX_CNT_LO   6'h2c
`define TCP_IDX_CNT_HI   6'h2d
`define TCP_IDX_CAPCTL   6'h2e
`define TCP_IDX_CTL_A    6'h2f
`define TCP_IDX_STATUS   6'h38

// timer_control_a fields
`define TCP_CTL_MODE_A   7:6
`define TCP_CTL_MODE_B   5:4
`define TCP_BIT_CTC      3
`define TCP_CTL_RES      1:0
// capture control fields
`define TCP_BIT_NCANCEL  7
`define TCP_BIT_EDGE     6
// status fields, write one to clear
`define TCP_BIT_CAPF     0
`define TCP_BIT_OVF      1

// ceilings and widths
`define TCP_TOP8         16'h00ff
`define TCP_TOP9         16'h01ff
`define TCP_TOP10        16'h03ff
`define TCP_MAX16        16'hffff
`define TCP_ONE16        16'h0001
`define TCP_NC_SAMPLES   4

// reset values and bus answers
`define TCP_RST_BYTE     8'h00
`define TCP_RST_WORD     16'h0000
`define TCP_RESP_OKAY    2'b00
`define TCP_RESP_SLVERR  2'b10

`endif

// ==== pkg/tcp_pkg.sv ====
/*
  types shared by the capture / pwm timer files.
  assumes tcp_defs.svh holds every numeric constant.
*/
package tcp_pkg;

  // resolution select, all zero means normal counting
  typedef enum logic [1:0]
  {
    TCP_RES_NORMAL = 2'b00,
    TCP_RES_8      = 2'b01,
    TCP_RES_9      = 2'b10,
    TCP_RES_10     = 2'b11
  } tcp_res_e;

  // compare output mode per channel
  typedef enum logic [1:0]
  {
    TCP_COM_OFF0 = 2'b00,
    TCP_COM_OFF1 = 2'b01,
    TCP_COM_CLR  = 2'b10,
    TCP_COM_SET  = 2'b11
  } tcp_com_e;

  // count direction of the phase-correct counter
  typedef enum logic
  {
    TCP_DIR_DOWN = 1'b0,
    TCP_DIR_UP   = 1'b1
  } tcp_dir_e;

  typedef logic [15:0] tcp_word_t;

endpackage : tcp_pkg

// ==== pkg/tcp_cap_if.sv ====
/*
  capture link between the timer core and its capture pin filter.
  assumes both ends run on the same clock.
*/
`timescale 1ns/10ps
interface tcp_cap_if;
  logic noise_cancel;  // four-sample filter enable
  logic edge_sel;      // 1 rising, 0 falling
  logic capture_evt;   // one-cycle pulse on a qualified edge

  modport core (output noise_cancel, output edge_sel, input capture_evt);
  modport filt (input noise_cancel, input edge_sel, output capture_evt);
endinterface : tcp_cap_if

// ==== rtl/tcp_cap_filter.sv ====
/*
  capture pin synchroniser, noise filter and edge detector.
  assumes the pin is asynchronous to i_clk and the core sets the controls.
*/
`timescale 1ns/10ps
`include "tcp_defs.svh"
module tcp_cap_filter
(
  // clock and reset
  input  wire logic i_clk,
  input  wire logic i_srst,
  // capture pin
  input  wire logic i_capture_pin,
  // link to core
  tcp_cap_if.filt   cap
);
  import tcp_pkg::*;

  logic                       sync1_r;  // first stage, read only by sync2_r
  logic                       sync2_r;
  logic                       sync3_r;
  logic                       level_r;  // settled pin level
  logic [`TCP_NC_SAMPLES-1:0] hist_r;   // last settled samples
  logic                       filt_r;   // level after filter
  logic                       filt_nxt;
  logic                       evt_r;

  // three-flop synchroniser; change counts once stages two and three agree
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
      sync3_r <= 1'b0;
      level_r <= 1'b0;
    end
    else
    begin
      sync1_r <= i_capture_pin;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
      if (sync2_r == sync3_r)
        level_r <= sync3_r;
    end
  end

  // filter: with cancel on, only four equal samples move the level
  always_comb
  begin
    filt_nxt = filt_r;
    if (!cap.noise_cancel)
      filt_nxt = level_r;
    else if (&{hist_r[`TCP_NC_SAMPLES-2:0], level_r})
      filt_nxt = 1'b1;
    else if (~|{hist_r[`TCP_NC_SAMPLES-2:0], level_r})
      filt_nxt = 1'b0;
  end

  // edge of the selected polarity gives one capture pulse
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      hist_r <= '0;
      filt_r <= 1'b0;
      evt_r  <= 1'b0;
    end
    else
    begin
      hist_r <= {hist_r[`TCP_NC_SAMPLES-2:0], level_r};
      filt_r <= filt_nxt;
      evt_r  <= (filt_nxt != filt_r) && (filt_nxt == cap.edge_sel);
    end
  end

  assign cap.capture_evt = evt_r;

  // with cancel on, filter never passes a level that four samples have not shown
  a_nc_hold: assert property (@(posedge i_clk) disable iff (i_srst)
    (cap.noise_cancel && $changed(filt_r)) |-> (hist_r == {`TCP_NC_SAMPLES{filt_r}}))
    else $error("noise filter moved without four equal samples");

endmodule : tcp_cap_filter

// ==== bench/tcp_far_side.sv ====
/*
  far side model: drives the capture pin and counts pwm pin high time.
  assumes the bench calls set_pin right after a rising edge of i_clk.
*/
`timescale 1ns/10ps
module tcp_far_side
(
  // clock
  input  wire logic i_clk,
  // pwm pins from the timer
  input  wire logic i_pwm_a,
  input  wire logic i_pwm_a_oe,
  input  wire logic i_pwm_b,
  input  wire logic i_pwm_b_oe,
  // capture pin into the timer
  output logic      o_capture_pin,
  // running high-time counts
  output int        o_hi_a,
  output int        o_hi_b
);
  // pin starts low so no edge shows at reset release
  initial
  begin
    o_capture_pin = 1'b0;
    o_hi_a = 0;
    o_hi_b = 0;
  end

  // level change on command, non-blocking so it lands after the edge
  task set_pin(input logic lvl);
    o_capture_pin <= lvl;
  endtask : set_pin

  // a pin counts only while driven: an undriven pin has no level
  always @(posedge i_clk)
  begin
    o_hi_a <= o_hi_a + int'(i_pwm_a_oe && i_pwm_a);
    o_hi_b <= o_hi_b + int'(i_pwm_b_oe && i_pwm_b);
  end
endmodule : tcp_far_side

// ==== bench/timer16_capture_and_pwm_bench.sv ====
/*
  self-checking bench for the 16-bit capture / pwm timer.
  assumes tcp_far_side drives the capture pin and measures the pwm pins.
*/
`timescale 1ns/10ps
`include "tcp_defs.svh"
module timer16_capture_and_pwm_bench;
  // clock, reset and bookkeeping
  logic             clk       = 1'b0;
  logic             srst      = 1'b1;
  int               cyc       = 0;
  int               err_total = 0;
  int               checked   = 0;
  logic [1:0]       wresp     = 2'b00;  // last write response
  // bus master side, idle at time zero
  logic [7:0]       awaddr    = 8'h00;
  logic [7:0]       araddr    = 8'h00;
  logic [31:0]      wdata     = 32'h0;
  logic [3:0]       wstrb     = 4'h0;
  logic             awvalid   = 1'b0;
  logic             wvalid    = 1'b0;
  logic             bready    = 1'b0;
  logic             arvalid   = 1'b0;
  logic             rready    = 1'b0;
  // answers from the timer and the far side model
  wire logic        awready, wready, bvalid, arready, rvalid;
  wire logic [1:0]  bresp, rresp;
  wire logic [31:0] rdata;
  wire logic        cap_pin, pa, pa_oe, pb, pb_oe;
  int               hi_a, hi_b;

  // 125 MHz clock and a free cycle count
  always #4 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;

  tcp_timer16 DUT
  (
    .i_clk(clk), .i_srst(srst),
    .i_s_axi_awaddr(awaddr), .i_s_axi_awvalid(awvalid), .o_s_axi_awready(awready),
    .i_s_axi_wdata(wdata), .i_s_axi_wstrb(wstrb), .i_s_axi_wvalid(wvalid),
    .o_s_axi_wready(wready), .o_s_axi_bresp(bresp), .o_s_axi_bvalid(bvalid),
    .i_s_axi_bready(bready), .i_s_axi_araddr(araddr), .i_s_axi_arvalid(arvalid),
    .o_s_axi_arready(arready), .o_s_axi_rdata(rdata), .o_s_axi_rresp(rresp),
    .o_s_axi_rvalid(rvalid), .i_s_axi_rready(rready), .i_capture_pin(cap_pin),
    .o_pwm_out_a(pa), .o_pwm_out_a_oe(pa_oe), .o_pwm_out_b(pb), .o_pwm_out_b_oe(pb_oe)
  );

  tcp_far_side FAR
  (
    .i_clk(clk), .i_pwm_a(pa), .i_pwm_a_oe(pa_oe), .i_pwm_b(pb), .i_pwm_b_oe(pb_oe),
    .o_capture_pin(cap_pin), .o_hi_a(hi_a), .o_hi_b(hi_b)
  );

  // one comparison, counted, reported at once on mismatch
  task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  // write one byte: address and data offered together, held until taken
  task wr(input logic [5:0] idx, input logic [7:0] d, input logic [3:0] strb = 4'hf);
    awaddr  <= {idx, 2'b00};
    wdata   <= {24'h0, d};
    wstrb   <= strb;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    @(posedge clk);
    while (awready !== 1'b1 || wready !== 1'b1) @(posedge clk);
    awvalid <= 1'b0;
    wvalid  <= 1'b0;
    bready  <= 1'b1;
    @(posedge clk);
    while (bvalid !== 1'b1) @(posedge clk);
    wresp = bresp;
    bready  <= 1'b0;
  endtask : wr

  // read one byte, data and response taken at the rvalid edge
  task rd(input logic [5:0] idx, output logic [7:0] d, output logic [1:0] r);
    araddr  <= {idx, 2'b00};
    arvalid <= 1'b1;
    @(posedge clk);
    while (arready !== 1'b1) @(posedge clk);
    arvalid <= 1'b0;
    rready  <= 1'b1;
    @(posedge clk);
    while (rvalid !== 1'b1) @(posedge clk);
    d = rdata[7:0];
    r = rresp;
    rready  <= 1'b0;
  endtask : rd

  // low byte first, high byte then comes from the shared latch
  task get_cap(output logic [15:0] v);
    logic [1:0] r;
    rd(`TCP_IDX_CAP_LO, v[7:0], r);
    rd(`TCP_IDX_CAP_HI, v[15:8], r);
  endtask : get_cap

  // reset values, read-only capture, unmapped index
  task t_regs;
    logic [7:0]  d;
    logic [1:0]  r;
    logic [15:0] v;
    get_cap(v);
    chk(v, `TCP_RST_WORD, "capture reset");
    wr(`TCP_IDX_CAP_LO, 8'h5a);
    chk(wresp, `TCP_RESP_OKAY, "mapped write resp");
    get_cap(v);
    chk(v, `TCP_RST_WORD, "capture write ignored");
    rd(6'h3f, d, r);
    chk(r, `TCP_RESP_SLVERR, "unmapped resp");
    wr(6'h3f, 8'h00);
    chk(wresp, `TCP_RESP_SLVERR, "unmapped write resp");
    wr(`TCP_IDX_CTL_A, 8'h01, 4'he);
    rd(`TCP_IDX_CTL_A, d, r);
    chk(d, `TCP_RST_BYTE, "write without lane 0 dropped");
    chk(r, `TCP_RESP_OKAY, "mapped read resp");
    $display("regs test done");
  endtask : t_regs

  // edge polarity, flag, captured spacing, noise filter
  task t_cap;
    logic [7:0]  d;
    logic [1:0]  r;
    logic [15:0] c1, c2, dc;
    int          t1, t2;
    wr(`TCP_IDX_CAPCTL, 8'h40);
    wr(`TCP_IDX_STATUS, 8'h03);
    FAR.set_pin(1'b1);
    t1 = cyc;
    repeat (20) @(posedge clk);
    rd(`TCP_IDX_STATUS, d, r);
    chk(d[0], 1'b1, "flag on rising");
    get_cap(c1);
    wr(`TCP_IDX_STATUS, 8'h01);
    FAR.set_pin(1'b0);
    repeat (20) @(posedge clk);
    rd(`TCP_IDX_STATUS, d, r);
    chk(d[0], 1'b0, "falling ignored");
    FAR.set_pin(1'b1);
    t2 = cyc;
    repeat (20) @(posedge clk);
    get_cap(c2);
    dc = c2 - c1;
    chk(dc, 16'(t2 - t1), "capture spacing");
    wr(`TCP_IDX_CAPCTL, 8'h00);
    wr(`TCP_IDX_STATUS, 8'h01);
    FAR.set_pin(1'b0);
    repeat (20) @(posedge clk);
    rd(`TCP_IDX_STATUS, d, r);
    chk(d[0], 1'b1, "falling taken");
    wr(`TCP_IDX_CAPCTL, 8'hc0);
    wr(`TCP_IDX_STATUS, 8'h01);
    FAR.set_pin(1'b1);
    repeat (3) @(posedge clk);
    FAR.set_pin(1'b0);
    repeat (20) @(posedge clk);
    rd(`TCP_IDX_STATUS, d, r);
    chk(d[0], 1'b0, "short pulse filtered");
    FAR.set_pin(1'b1);
    repeat (20) @(posedge clk);
    rd(`TCP_IDX_STATUS, d, r);
    chk(d[0], 1'b1, "long pulse taken");
    $display("capture test done");
  endtask : t_cap

  // drive reset to a level, then let n rising edges pass
  task set_rst(input logic lvl, input int n);
    srst <= lvl;
    repeat (n) @(posedge clk);
  endtask : set_rst

  // reset in mid-run: a captured value and the flags must clear
  task t_rst;
    logic [7:0]  d;
    logic [1:0]  r;
    logic [15:0] v;
    FAR.set_pin(1'b0);
    repeat (20) @(posedge clk);
    set_rst(1'b1, 2);
    set_rst(1'b0, 1);
    get_cap(v);
    chk(v, `TCP_RST_WORD, "capture after reset");
    rd(`TCP_IDX_STATUS, d, r);
    chk(d, `TCP_RST_BYTE, "flags after reset");
    $display("reset test done");
  endtask : t_rst

  // one pwm setting: readback, enables, high time over a period, overflow
  task t_pwm(input logic [7:0] ctl, input logic [15:0] top, ca, cb, input int ea, eb);
    int          per, a0, b0;
    logic [7:0]  d, h;
    logic [1:0]  r;
    per = ctl[3] ? top + 1 : 2 * top;
    wr(`TCP_IDX_CTL_A, ctl);
    wr(`TCP_IDX_CMPA_HI, ca[15:8]);
    wr(`TCP_IDX_CMPA_LO, ca[7:0]);
    wr(`TCP_IDX_CMPB_HI, cb[15:8]);
    wr(`TCP_IDX_CMPB_LO, cb[7:0]);
    rd(`TCP_IDX_CMPA_HI, h, r);
    rd(`TCP_IDX_CMPA_LO, d, r);
    chk({h, d}, ca & top, "compare readback");
    repeat (2 * per + 4) @(posedge clk);
    chk(pa_oe, ctl[7], "enable a");
    chk(pb_oe, ctl[5], "enable b");
    wr(`TCP_IDX_STATUS, 8'h02);
    a0 = hi_a;
    b0 = hi_b;
    repeat (per) @(posedge clk);
    chk(hi_a - a0, ea, "high time a");
    chk(hi_b - b0, eb, "high time b");
    rd(`TCP_IDX_STATUS, d, r);
    chk(d[1], 1'b1, "overflow each period");
    rd(`TCP_IDX_CNT_LO, d, r);
    rd(`TCP_IDX_CNT_HI, h, r);
    chk({h, d} & ~top, `TCP_RST_WORD, "counter above resolution");
    $display("pwm test done ctl %h", ctl);
  endtask : t_pwm

  // counts, verdict and the only end of the run
  task end_of_test;
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : end_of_test

  // main sequence: reset two cycles, then every scenario in turn
  initial
  begin
    set_rst(1'b1, 2);
    set_rst(1'b0, 1);
    t_regs();
    t_cap();
    t_rst();
    t_pwm(8'hb9, 16'h00ff, 16'h0140, 16'h0000, 65, 255);
    t_pwm(8'ha9, 16'h00ff, 16'h00ff, 16'h0000, 256, 1);
    t_pwm(8'hb1, 16'h00ff, 16'h0000, 16'h0000, 0, 510);
    t_pwm(8'hb2, 16'h01ff, 16'h01ff, 16'h01ff, 1022, 0);
    t_pwm(8'hb3, 16'h03ff, 16'h0123, 16'h0123, 582, 1464);
    t_pwm(8'haa, 16'h01ff, 16'h0100, 16'h03ff, 257, 512);
    t_pwm(8'hab, 16'h03ff, 16'h03fe, 16'h0000, 1023, 1);
    t_pwm(8'h49, 16'h00ff, 16'h0080, 16'h0080, 0, 0);
    end_of_test();
  end

  // watchdog: the run needs about 18k cycles, 40k leaves room
  initial
  begin
    #320000;
    err_total++;
    end_of_test();
  end
endmodule : timer16_capture_and_pwm_bench
